//--- design/splp_pkg.sv
// Purpose: Shared constants and types of the serial programming link front end
// Assumes: One reference clock; the programmer clock is sampled as a plain pin
// Notes:   Bit counts are in programmer clock periods, not reference cycles
package splp_pkg;

  // Frame layout
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [3:0]  RX_LAST_BIT   = 4'hA;  // Index of second stop bit after start
  localparam logic [3:0]  TX_FRAME_BITS = 4'hC;  // Start, data, parity, two stops
  localparam int unsigned PAR_POS       = 8;
  localparam int unsigned STOP1_POS     = 9;
  localparam int unsigned STOP2_POS     = 10;
  localparam int unsigned BREAK_BITS    = 12;    // Low bit times forming a break

  // Direction change guard time, in bit periods
  localparam logic [7:0]  GUARD_RESET   = 8'h80;
  localparam logic [8:0]  GUARD_EXTRA   = 9'h002;

  // Positions in the synchronised pin vector
  localparam int unsigned SYNC_W        = 4;
  localparam int unsigned PIN_CLK       = 0;
  localparam int unsigned PIN_DATA      = 1;
  localparam int unsigned PIN_RST_N     = 2;
  localparam int unsigned PIN_HV        = 3;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 4'h7;  // Clock, data, reset pin high; no high voltage

  // Link sequencing; Gray steps out of idle along receive and along transmit; returns from break wait and transmit change two bits
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_RX       = 3'b001,
    ST_BRK_WAIT = 3'b011,
    ST_GUARD    = 3'b100,
    ST_TX       = 3'b101
  } splp_state_e;

  // Report towards the access side, one cycle per event
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       frame_err;
    logic       parity_err;
    logic       brk;
    logic       collision;
  } splp_event_s;

endpackage : splp_pkg

//--- design/splp_sync.sv
// Purpose: Two-stage synchroniser for a vector of asynchronous pins
// Assumes: Each bit is an independent level
// Notes:   Only the second stage is visible outside
module splp_sync
  import splp_pkg::*;
#(
  parameter int unsigned      WIDTH    = SYNC_W,
  parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two flops per bit, reset to each pin's idle level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q   <= IDLE_VAL;
      sync_out <= IDLE_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : splp_sync

//--- design/splp_edge.sv
// Purpose: Edge finder for the synchronised programmer clock
// Assumes: Input is already on the reference clock
// Notes:   Pulses last one reference cycle
module splp_edge (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Level and edges
  input  wire logic level_in,
  output logic      rise,
  output logic      fall
);

  logic prev_q;

  // Previous level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prev_q <= 1'b1; // Idle level of the clock pin, no false edge
    end else begin
      prev_q <= level_in;
    end
  end

  // Edge pulses
  assign rise = level_in & ~prev_q;
  assign fall = ~level_in & prev_q;

endmodule : splp_edge

//--- design/splp_phy.sv
// Purpose: Physical layer of a three-pin half-duplex programming link
// Assumes: Programmer clock far slower than ref_clk (four or more cycles a half)
// Notes:   Access side commands direction; error state kept here
//          Pins pass two reference flops, so edges are seen late
//          Guard time counts programmer falls from the request on
//          A break clears the error state and is not an error
//          Collision is looked for only while the driver is off
//          Link logic sits in reset outside a programming session
//
// Behaviour
// (R1) Frame: start, eight data, parity, two stops
// (R2) Character bits travel least significant first
// (R3) Parity is exclusive-or of data bits
// (R4) Break is twelve or more low bits
// (R5) Change on falling, sample on rising edges
// (R6) Receive by default; access side picks direction
// (R7) Shift in bits through second stop, present byte
// (R8) Stop bit read low flags frame error
// (R9) Accumulate parity, compare, flag mismatch
// (R10) All-zero frame reports break
// (R11) Receive exception enters error, stays receiving
// (R12) Transmit shifts one full frame per load
// (R13) Drive zeros; ones driven only first period
// (R14) Released driver reading low means collision
// (R15) Collision releases driver, receive, error state
// (R16) Turnaround idles guard time plus two bits
// (R17) Guard time defaults to 128 bits
// (R18) Programmer idles one bit before sending
// (R19) Programmer holds enable for whole session
// (R20) Programmer idles data sixteen clocks first
// (R21) Leave on enable release if nvm disabled
// (R22) Messages start with programmer instruction byte
// (R23) Error state ignores frames until break
// (R24) Idle high; first low sample is start
// (R25) Long low run is one break; await high
module splp_phy
  import splp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Programming pins
  input  wire logic        prog_clock_in,
  input  wire logic        prog_data_i,
  output logic             prog_data_o,
  output logic             prog_data_oe,
  input  wire logic        prog_reset_n,
  input  wire logic        high_voltage_enable_level,
  // Device configuration and state
  input  wire logic        reset_pin_disable_fuse,
  input  wire logic        nvm_access_enable,
  // Guard time setting
  input  wire logic [7:0]  phy_guard_control,
  input  wire logic        guard_load,
  // Access side: transmit
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_request,
  output logic             tx_busy,
  output logic             tx_done,
  // Access side: receive and status
  output splp_event_s      link_event,
  output logic             error_state,
  output logic             mode_tx,
  output logic             session_active
);

  // Synchronised pins
  logic [SYNC_W-1:0] pins_s;
  logic              clk_s;
  logic              dat_s;
  logic              clk_rise;
  logic              clk_fall;

  // Session and control
  logic              enable_req;
  logic              phy_rst;
  logic [7:0]        guard_q;
  splp_state_e       state_q;

  // Receive path
  logic [10:0]       rx_sh_q;
  logic [3:0]        rx_cnt_q;
  logic              rx_par_q;
  logic [10:0]       frame_w;
  logic              frame_end;
  logic              rx_brk;
  logic              rx_ferr;
  logic              rx_perr;
  logic              rx_take;
  logic              rx_fault;

  // Transmit path
  logic [7:0]        tx_hold_q;
  logic [10:0]       tx_sh_q;
  logic [3:0]        tx_cnt_q;
  logic [8:0]        guard_cnt_q;
  logic              last_bit_q;
  logic              tx_go;
  logic              tx_start_bit;
  logic              collide;
  logic              guard_tick;
  logic              tx_step;
  logic              tx_last_fall;
  logic              tx_par;
  logic              tx_oe_next;

  // Pins cross into ref_clk before any use
  splp_sync #(
    .WIDTH    (SYNC_W),
    .IDLE_VAL (SYNC_IDLE)
  ) u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({high_voltage_enable_level, prog_reset_n, prog_data_i, prog_clock_in}),
    .sync_out (pins_s)
  );

  assign clk_s = pins_s[PIN_CLK];
  assign dat_s = pins_s[PIN_DATA];

  // Programmer clock edges
  splp_edge u_clk_edge (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .level_in (clk_s),
    .rise     (clk_rise),
    .fall     (clk_fall)
  );

  // Enable by low reset pin, or high voltage when pin is not a reset
  assign enable_req = ~pins_s[PIN_RST_N] | (reset_pin_disable_fuse & pins_s[PIN_HV]);

  // Session entry and exit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      session_active <= 1'b0;
    end else if (enable_req) begin
      session_active <= 1'b1;
    end else if (!nvm_access_enable) begin
      session_active <= 1'b0; // R21
    end
  end

  // Link logic runs only inside a session
  assign phy_rst = srst | ~session_active;

  // Guard time setting
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      guard_q <= GUARD_RESET; // R17
    end else if (guard_load) begin
      guard_q <= phy_guard_control;
    end
  end

  // Receive sample strobe, one per programmer rising edge
  assign rx_take   = (state_q == ST_RX) && clk_rise; // R5

  // Whole frame as seen at the second stop sample
  assign frame_w   = {dat_s, rx_sh_q[10:1]};
  assign frame_end = rx_take && (rx_cnt_q == RX_LAST_BIT);
  assign rx_brk    = frame_end && (frame_w == '0); // R10 R4
  assign rx_ferr   = frame_end && !rx_brk && (!frame_w[STOP1_POS] || !frame_w[STOP2_POS]); // R8
  assign rx_perr   = frame_end && !rx_brk && (rx_par_q != frame_w[PAR_POS]); // R9 R3
  assign rx_fault  = rx_ferr || rx_perr; // R11

  // Collision only while the driver is released
  assign collide = (state_q == ST_TX) && clk_rise && !prog_data_oe && !dat_s; // R14

  // Transmit request accepted only when idle and healthy
  assign tx_go = (state_q == ST_IDLE) && tx_request && !error_state && !clk_rise; // R6

  // Guard expired on this falling edge
  assign tx_start_bit = (state_q == ST_GUARD) && clk_fall && (guard_cnt_q == '0);

  // Guard countdown step on each falling edge while the count is not yet zero
  assign guard_tick = (state_q == ST_GUARD) && clk_fall && (guard_cnt_q != '0); // R16

  // Transmit bit step, and the fall that ends the frame
  assign tx_step      = (state_q == ST_TX) && clk_fall; // R5
  assign tx_last_fall = tx_step && (tx_cnt_q == TX_FRAME_BITS); // R12

  // Even parity of the outgoing byte
  assign tx_par = ^tx_hold_q; // R3

  // Drive a zero, or the first one after a zero
  assign tx_oe_next = !tx_sh_q[0] || !last_bit_q; // R13

  // Link sequencer
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      state_q <= ST_IDLE; // R6
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tx_go) begin
            state_q <= ST_GUARD;
          end else if (clk_rise && !dat_s) begin
            state_q <= ST_RX; // R24
          end
        end
        ST_RX: begin
          if (frame_end) begin
            state_q <= rx_brk ? ST_BRK_WAIT : ST_IDLE;
          end
        end
        ST_BRK_WAIT: begin
          if (clk_rise && dat_s) begin
            state_q <= ST_IDLE; // R25
          end
        end
        ST_GUARD: begin
          if (tx_start_bit) begin
            state_q <= ST_TX;
          end
        end
        ST_TX: begin
          if (collide) begin
            state_q <= ST_IDLE; // R15
          end else if (tx_last_fall) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive shift register, sampled on rising edges
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      rx_sh_q  <= '0;
      rx_cnt_q <= '0;
      rx_par_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      rx_cnt_q <= '0;
      rx_par_q <= 1'b0;
    end else if (rx_take) begin
      rx_sh_q  <= {dat_s, rx_sh_q[10:1]}; // R7 R2 R5
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_cnt_q < 4'(DATA_BITS)) begin
        rx_par_q <= rx_par_q ^ dat_s; // R9
      end
    end
  end

  // Access side error state
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      error_state <= 1'b0;
    end else if (rx_fault || collide) begin
      error_state <= 1'b1; // R11 R15
    end else if (rx_brk) begin
      error_state <= 1'b0; // R23
    end
  end

  // Event report, one cycle per event
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      link_event <= '0;
    end else begin
      link_event.valid      <= frame_end && !rx_brk && !rx_ferr && !rx_perr
                               && !error_state; // R7 R23 R22
      link_event.frame_err  <= rx_ferr;
      link_event.parity_err <= rx_perr;
      link_event.brk        <= rx_brk;
      link_event.collision  <= collide;
      if (frame_end) begin
        link_event.data <= frame_w[7:0];
      end
    end
  end

  // Guard counter: guard setting plus two idle bits
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      guard_cnt_q <= '0;
    end else if (tx_go) begin
      guard_cnt_q <= {1'b0, guard_q} + GUARD_EXTRA; // R16
    end else if (guard_tick) begin
      guard_cnt_q <= guard_cnt_q - 9'h001;
    end
  end

  // Byte held from request to start bit
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      tx_hold_q <= '0;
    end else if (tx_go) begin
      tx_hold_q <= tx_byte;
    end
  end

  // Transmit shifter and pin driver, changed on falling edges; driver released on the rising edge of a collision
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      tx_sh_q      <= '1;
      tx_cnt_q     <= '0;
      last_bit_q   <= 1'b1;
      prog_data_o  <= 1'b1;
      prog_data_oe <= 1'b0;
    end else if (collide) begin
      prog_data_oe <= 1'b0; // R15
      prog_data_o  <= 1'b1;
    end else if (tx_start_bit) begin
      tx_sh_q      <= {2'b11, tx_par, tx_hold_q}; // R12 R1 R3 R2
      tx_cnt_q     <= 4'h1;
      last_bit_q   <= 1'b0;
      prog_data_o  <= 1'b0; // R5
      prog_data_oe <= 1'b1; // R13
    end else if (tx_step) begin
      if (tx_cnt_q == TX_FRAME_BITS) begin
        prog_data_oe <= 1'b0;
        prog_data_o  <= 1'b1;
      end else begin
        tx_sh_q      <= {1'b1, tx_sh_q[10:1]};
        tx_cnt_q     <= tx_cnt_q + 4'h1;
        last_bit_q   <= tx_sh_q[0];
        prog_data_o  <= tx_sh_q[0]; // R5
        prog_data_oe <= tx_oe_next; // R13
      end
    end
  end

  // Direction and completion status
  always_ff @(posedge ref_clk) begin
    if (phy_rst) begin
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      mode_tx <= 1'b0;
    end else begin
      tx_done <= tx_last_fall && !collide; // R12
      if (tx_go) begin
        tx_busy <= 1'b1;
        mode_tx <= 1'b1;
      end else if (collide || tx_last_fall) begin
        tx_busy <= 1'b0;
        mode_tx <= 1'b0; // R6 R15
      end
    end
  end

endmodule : splp_phy

//--- verif/splp_phy_assertions.sv
// Purpose: Port-level checks of the programming link front end
// Assumes: Single reference clock domain
// Notes:   Bound onto every splp_phy instance
module splp_phy_assertions
  import splp_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Observed outputs
  input wire logic        prog_data_o,
  input wire logic        prog_data_oe,
  input wire logic        tx_busy,
  input wire logic        tx_done,
  input wire splp_event_s link_event,
  input wire logic        error_state,
  input wire logic        mode_tx,
  input wire logic        session_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // Transfer steps
  sequence s_tx_start;
    $rose(tx_busy);
  endsequence
  sequence s_rx_fault;
    link_event.parity_err || link_event.frame_err;
  endsequence

  property p_rel_high;
    !prog_data_oe |-> prog_data_o;
  endproperty
  property p_oe_rise_zero;
    $rose(prog_data_oe) |-> !prog_data_o;
  endproperty
  property p_tx_start;
    s_tx_start |-> mode_tx && !prog_data_oe;
  endproperty
  property p_rx_quiet;
    !mode_tx |-> !prog_data_oe;
  endproperty
  property p_busy_mode;
    tx_busy |-> mode_tx;
  endproperty
  property p_coll;
    link_event.collision |-> error_state && !mode_tx && !$past(prog_data_oe);
  endproperty
  property p_fault;
    s_rx_fault |-> error_state && !link_event.valid
                   ##1 !(link_event.parity_err || link_event.frame_err);
  endproperty
  property p_brk;
    link_event.brk |-> !error_state ##1 !link_event.brk;
  endproperty
  property p_done;
    tx_done |-> !prog_data_oe ##1 !tx_done;
  endproperty
  property p_sess;
    !session_active |=> !tx_busy && !error_state && !mode_tx;
  endproperty

  a_rel_high:     assert property (p_rel_high) else $error("released pin not high");
  a_oe_rise_zero: assert property (p_oe_rise_zero) else $error("driver on for a one");
  a_tx_start:     assert property (p_tx_start) else $error("no idle at turnaround");
  a_rx_quiet:     assert property (p_rx_quiet) else $error("drive in receive");
  a_busy_mode:    assert property (p_busy_mode) else $error("busy outside transmit");
  a_coll:         assert property (p_coll) else $error("bad collision report");
  a_fault:        assert property (p_fault) else $error("fault without error");
  a_brk:          assert property (p_brk) else $error("break kept error");
  a_done:         assert property (p_done) else $error("bad done pulse");
  a_sess:         assert property (p_sess) else $error("link live outside session");
endmodule : splp_phy_assertions

bind splp_phy splp_phy_assertions u_chk (
  .ref_clk(ref_clk), .srst(srst), .prog_data_o(prog_data_o), .prog_data_oe(prog_data_oe),
  .tx_busy(tx_busy), .tx_done(tx_done), .link_event(link_event),
  .error_state(error_state), .mode_tx(mode_tx), .session_active(session_active)
);

//--- verif/splp_prog_model.sv
// Purpose: External programmer driving clock and data
// Assumes: Pull-up keeps the released data wire high
// Notes:   Clock rests high between frames
module splp_prog_model (
  // Pins
  output logic      prog_clock_in,
  output logic      prog_data_i,
  input  wire logic dev_o,
  input  wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en = 1'b0;
  logic val = 1'b1;

  // Wire level from both drivers and the pull-up
  assign prog_data_i = dev_oe ? dev_o : (en ? val : 1'b1);
  initial prog_clock_in = 1'b1;

  // One bit: change on fall, sample on rise
  task automatic bitx(input logic v, input logic d, output logic s);
    prog_clock_in = 1'b0;
    en = d;
    val = v;
    #160;
    prog_clock_in = 1'b1;
    s = prog_data_i;
    #160;
  endtask : bitx

  // Whole frame, with optional parity or stop fault
  task automatic send(input logic [7:0] b, input logic pf, input logic sf);
    logic s;
    bitx(1'b0, 1'b1, s);
    for (int i = 0; i < 8; i++) bitx(b[i], 1'b1, s);
    bitx(^b ^ pf, 1'b1, s);
    bitx(!sf, 1'b1, s);
    bitx(1'b1, 1'b1, s);
    bitx(1'b1, 1'b0, s);
  endtask : send

  // Low run, then release
  task automatic brk(input int n);
    logic s;
    for (int i = 0; i < n; i++) bitx(1'b0, 1'b1, s);
    bitx(1'b1, 1'b0, s);
  endtask : brk

  // Data held high before the first frame
  task automatic idle(input int n);
    logic s;
    for (int i = 0; i < n; i++) bitx(1'b1, 1'b1, s);
  endtask : idle

  // Clock a device frame in; optionally pull low on a released bit
  task automatic get(input logic col, output int idl, output logic [11:0] f);
    logic s;
    f = '1;
    idl = -1;
    while (f[0] && idl < 400) begin
      bitx(1'b1, 1'b0, f[0]);
      idl++;
    end
    for (int i = 1; i < 12; i++) bitx(!(col && i == 3), col && i == 3, f[i]);
    bitx(1'b1, 1'b0, s);
  endtask : get
endmodule : splp_prog_model

//--- verif/splp_phy_tb.sv
// Purpose: Self-checking bench of the programming link front end
// Assumes: Programmer model clocks at 320 ns
// Notes:   Short guard loaded after the default one is measured
module splp_phy_tb
  import splp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Bench signals
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_p, data_i, data_o, data_oe, tx_busy, tx_done, err_st, mode_tx, sess;
  logic        rst_n = 1'b1, hv = 1'b0, fuse = 1'b0, nvm = 1'b0, g_ld = 1'b0;
  logic        tx_req = 1'b0;
  logic [7:0]  g_ctl = 8'h03;
  logic [7:0]  tx_b = 8'h00;
  splp_event_s ev;
  int          errors = 0, tests_run = 0;
  int          n_v = 0, n_pe = 0, n_fe = 0, n_br = 0, n_co = 0, n_dn = 0;
  logic [7:0]  exp_q[$];

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  splp_phy dut (
    .ref_clk(ref_clk), .srst(srst), .prog_clock_in(clk_p), .prog_data_i(data_i),
    .prog_data_o(data_o), .prog_data_oe(data_oe), .prog_reset_n(rst_n),
    .high_voltage_enable_level(hv), .reset_pin_disable_fuse(fuse), .nvm_access_enable(nvm),
    .phy_guard_control(g_ctl), .guard_load(g_ld), .tx_byte(tx_b), .tx_request(tx_req),
    .tx_busy(tx_busy), .tx_done(tx_done), .link_event(ev), .error_state(err_st),
    .mode_tx(mode_tx), .session_active(sess)
  );
  splp_prog_model prog (.prog_clock_in(clk_p), .prog_data_i(data_i), .dev_o(data_o),
    .dev_oe(data_oe));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk) #1;
  endtask : step

  // Tally pulses; every received byte against the model queue
  always @(negedge ref_clk) begin
    n_pe += int'(ev.parity_err === 1'b1);
    n_fe += int'(ev.frame_err === 1'b1);
    n_br += int'(ev.brk === 1'b1);
    n_co += int'(ev.collision === 1'b1);
    n_dn += int'(tx_done === 1'b1);
    if (ev.valid === 1'b1) begin
      n_v++;
      chk("rx_data", {8'h00, ev.data}, exp_q.size() ? {8'h00, exp_q.pop_front()} : 16'h0100);
    end
  end

  // Request a frame and read it back through the programmer
  task automatic tx(input logic [7:0] b, input logic col, input int g);
    int idl;
    logic [11:0] f;
    tx_b = b;
    tx_req = 1'b1;
    for (int k = 0; k < 8 && tx_busy !== 1'b1; k++) step(1);
    chk("busy", 16'(tx_busy), 16'h0001);
    tx_req = 1'b0;
    prog.get(col, idl, f);
    step(2);
    if (!col) begin
      chk("guard", 16'(idl), 16'(g + 2));
      chk("frame", {4'h0, f}, {4'h0, 2'b11, ^b, b, 1'b0});
    end
  endtask : tx

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  initial begin
    #1_000_000;
    errors++;
    end_sim;
  end

  // Main sequence
  initial begin
    logic [7:0] b;
    b = $urandom(32'hCB5C);
    step(10);
    srst = 1'b0;
    step(1);
    chk("reset", {11'h0, data_o, data_oe, sess, mode_tx, err_st}, 16'h0010);
    rst_n = 1'b0;
    step(4);
    chk("enter", 16'(sess), 16'h0001);
    prog.idle(16);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      prog.send(b, 1'b0, 1'b0);
    end
    step(2);
    chk("rx_count", 16'(n_v), 16'h0003);
    $display("test receive done");
    tx(8'($urandom), 1'b0, 128);
    g_ld = 1'b1;
    step(1);
    g_ld = 1'b0;
    tx(8'h00, 1'b0, 3);
    tx(8'($urandom), 1'b0, 3);
    chk("done", 16'(n_dn), 16'h0003);
    $display("test transmit done");
    prog.send(b, 1'b1, 1'b0);
    step(2);
    chk("parity", {15'h0, err_st}, 16'h0001);
    chk("parity_cnt", 16'(n_pe), 16'h0001);
    tx_req = 1'b1;
    step(3);
    chk("refused", 16'(tx_busy), 16'h0000);
    tx_req = 1'b0;
    prog.send(b, 1'b0, 1'b0);
    prog.brk(12);
    step(2);
    chk("ignored", 16'(n_v), 16'h0003);
    chk("break", {15'h0, err_st}, 16'h0000);
    chk("break_cnt", 16'(n_br), 16'h0001);
    prog.send(b, 1'b0, 1'b1);
    prog.brk(20);
    step(2);
    chk("stop", 16'(n_fe), 16'h0001);
    chk("long_break", 16'(n_br), 16'h0002);
    $display("test errors done");
    tx(8'hFF, 1'b1, 3);
    chk("collide", 16'(n_co), 16'h0001);
    chk("coll_state", {14'h0, err_st, mode_tx}, 16'h0002);
    prog.brk(12);
    nvm = 1'b1;
    rst_n = 1'b1;
    step(5);
    chk("persist", 16'(sess), 16'h0001);
    nvm = 1'b0;
    step(5);
    chk("leave", 16'(sess), 16'h0000);
    fuse = 1'b1;
    hv = 1'b1;
    step(5);
    chk("hv_entry", 16'(sess), 16'h0001);
    $display("test session done");
    end_sim;
  end
endmodule : splp_phy_tb
